// ---- hdl/peripheral_interrupt_logic.sv ----
// interrupt flags, enables, request output and host register access
// Notes on behaviour
// - request output is low while any flag 0-6 is set with its enable set.
// - request output drives both levels; never tri-stated, not for wired-or use.
// - flag register bit 7 reads the or of every flag anded with its enable.
// - writing the flag register clears each flag written as one.
// - enable write with bit 7 low clears enables written as one.
// - enable write with bit 7 high sets enables written as one.
// - enable register reads bit 7 as one and enables in bits 0-6.
// - control line edges set flags, line 2 only when it is an input; port output register access clears line 1, and line 2 unless independent.
// - eight shifts done sets shift flag; any shifter access clears it.
// - timer two time-out sets flag; read low counter or write high clears.
// - timer one time-out sets flag; read low counter or write high latch clears.
// - independent line 2 flag is not cleared by port output register access.
// - a flag stays set until one of its clearing actions happens.
// - selected read drives the addressed register; selected write stores data.
// - data lines are undriven whenever the device is not selected.
// - reset clears flags and enables and leaves the request output high.
`include "irq_logic_defs.svh"

module peripheral_interrupt_logic (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// host bus inputs
	input wire irq_logic_pkg::host_bus_type HOST_BUS,
	// interrupt sources
	input wire irq_logic_pkg::event_inputs_type EVENTS,
	// host data lines
	output logic [7:0] HOST_DATA_LINES_OUT,
	output logic HOST_DATA_LINES_OE,
	// interrupt request
	output logic INTERRUPT_REQUEST_N
);
	import irq_logic_pkg::*;

	logic [`NUM_SOURCES-1:0] flags;
	logic [`NUM_SOURCES-1:0] enables;
	logic [`NUM_SOURCES-1:0] set_vec;
	logic [`NUM_SOURCES-1:0] clear_vec;
	logic [7:0] peripheral_control_reg;
	logic phase_two_prev;
	logic selected;
	logic access_start;
	logic host_read;
	logic host_write;
	logic any_active_summary_bit;
	logic [3:0] rs;
	logic [7:0] wdata;
	logic [3:0] line_levels;
	logic [3:0] line_rising;
	logic [3:0] line_edges;
	logic port_a_access;
	logic port_b_access;
	logic port_a_line_2_indep;
	logic port_b_line_2_indep;
	logic port_a_line_2_input;
	logic port_b_line_2_input;
	logic enable_set_clear_select;
	logic [7:0] next_read_data;

	// bus decode
	always_comb begin
		selected = HOST_BUS.chip_select_high_active & ~HOST_BUS.chip_select_low_active_n;
		access_start = selected & HOST_BUS.phase_two_clock & ~phase_two_prev;
		host_read = access_start & HOST_BUS.read_not_write;
		host_write = access_start & ~HOST_BUS.read_not_write;
		rs = HOST_BUS.register_select_lines;
		wdata = HOST_BUS.host_data_lines;
		enable_set_clear_select = wdata[7];
	end

	// one access per rising phase two edge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			phase_two_prev <= 1'b0;
		end else begin
			phase_two_prev <= HOST_BUS.phase_two_clock;
		end
	end

	// peripheral control fields
	always_comb begin
		port_a_line_2_indep = peripheral_control_reg[`PCR_LINE_2_INDEPENDENT];
		port_b_line_2_indep = peripheral_control_reg[`PCR_PORT_B_BASE + `PCR_LINE_2_INDEPENDENT];
		port_a_line_2_input = ~peripheral_control_reg[`PCR_LINE_2_OUTPUT];
		port_b_line_2_input = ~peripheral_control_reg[`PCR_PORT_B_BASE + `PCR_LINE_2_OUTPUT];
		line_levels = {EVENTS.port_b_ctrl_line_2, EVENTS.port_b_ctrl_line_1,
			EVENTS.port_a_ctrl_line_2, EVENTS.port_a_ctrl_line_1};
		line_rising = {peripheral_control_reg[`PCR_PORT_B_BASE + `PCR_LINE_2_RISING],
			peripheral_control_reg[`PCR_PORT_B_BASE + `PCR_LINE_1_RISING],
			peripheral_control_reg[`PCR_LINE_2_RISING],
			peripheral_control_reg[`PCR_LINE_1_RISING]};
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			peripheral_control_reg <= `PCR_RESET;
		end else if (host_write && rs == `REG_PERIPHERAL_CONTROL) begin
			peripheral_control_reg <= wdata;
		end
	end

	// edge detectors for the four control lines
	genvar li;
	generate
		for (li = 0; li < 4; li = li + 1) begin : g_line
			ctrl_edge_detect u_edge (
				.clk(CLK),
				.srst(SRST),
				.line(line_levels[li]),
				.rising_sel(line_rising[li]),
				.edge_seen(line_edges[li])
			);
		end
	endgenerate

	// port output register accesses, read or write
	always_comb begin
		port_a_access = access_start & (rs == `REG_PORT_A_OUTPUT);
		port_b_access = access_start & (rs == `REG_PORT_B_OUTPUT);
	end

	// set sources, mapped onto the flag bits
	always_comb begin
		set_vec = '0;
		set_vec[`BIT_PORT_A_LINE_2] = line_edges[1] & port_a_line_2_input;
		set_vec[`BIT_PORT_A_LINE_1] = line_edges[0];
		set_vec[`BIT_SHIFT_DONE] = EVENTS.shift_done;
		set_vec[`BIT_PORT_B_LINE_2] = line_edges[3] & port_b_line_2_input;
		set_vec[`BIT_PORT_B_LINE_1] = line_edges[2];
		set_vec[`BIT_TIMER_TWO] = EVENTS.timer_two_timeout;
		set_vec[`BIT_TIMER_ONE] = EVENTS.timer_one_timeout;
	end

	// clear actions: explicit writes plus access side effects
	always_comb begin
		clear_vec = '0;
		if (host_write && rs == `REG_INTERRUPT_FLAGS) begin
			clear_vec = wdata[`NUM_SOURCES-1:0];
		end
		clear_vec[`BIT_PORT_A_LINE_2] = clear_vec[`BIT_PORT_A_LINE_2]
			| (port_a_access & ~port_a_line_2_indep);
		clear_vec[`BIT_PORT_A_LINE_1] = clear_vec[`BIT_PORT_A_LINE_1] | port_a_access;
		clear_vec[`BIT_PORT_B_LINE_2] = clear_vec[`BIT_PORT_B_LINE_2]
			| (port_b_access & ~port_b_line_2_indep);
		clear_vec[`BIT_PORT_B_LINE_1] = clear_vec[`BIT_PORT_B_LINE_1] | port_b_access;
		clear_vec[`BIT_SHIFT_DONE] = clear_vec[`BIT_SHIFT_DONE]
			| (access_start & rs == `REG_SERIAL_SHIFTER);
		clear_vec[`BIT_TIMER_TWO] = clear_vec[`BIT_TIMER_TWO]
			| (host_read & rs == `REG_TIMER_TWO_COUNTER_LOW)
			| (host_write & rs == `REG_TIMER_TWO_COUNTER_HIGH);
		clear_vec[`BIT_TIMER_ONE] = clear_vec[`BIT_TIMER_ONE]
			| (host_read & rs == `REG_TIMER_ONE_COUNTER_LOW)
			| (host_write & rs == `REG_TIMER_ONE_LATCH_HIGH);
	end

	// sticky flags, reset to zero
	genvar fi;
	generate
		for (fi = 0; fi < `NUM_SOURCES; fi = fi + 1) begin : g_flag
			flag_cell u_flag (
				.clk(CLK),
				.srst(SRST),
				.set(set_vec[fi]),
				.clear(clear_vec[fi]),
				.flag(flags[fi])
			);
		end
	endgenerate

	// enables change by set or clear masks
	always_ff @(posedge CLK) begin
		if (SRST) begin
			enables <= `ENABLES_RESET;
		end else if (host_write && rs == `REG_INTERRUPT_ENABLES) begin
			if (enable_set_clear_select) begin
				enables <= enables | wdata[`NUM_SOURCES-1:0];
			end else begin
				enables <= enables & ~wdata[`NUM_SOURCES-1:0];
			end
		end
	end

	// summary of active interrupts
	always_comb begin
		any_active_summary_bit = |(flags & enables);
	end

	// request output, driven both ways
	always_ff @(posedge CLK) begin
		if (SRST) begin
			INTERRUPT_REQUEST_N <= 1'b1;
		end else begin
			INTERRUPT_REQUEST_N <= ~any_active_summary_bit;
		end
	end

	// read data selection
	always_comb begin
		case (rs)
			`REG_INTERRUPT_FLAGS: next_read_data = {any_active_summary_bit, flags};
			`REG_INTERRUPT_ENABLES: next_read_data = {1'b1, enables};
			`REG_PERIPHERAL_CONTROL: next_read_data = peripheral_control_reg;
			default: next_read_data = `READ_IDLE;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			HOST_DATA_LINES_OUT <= `READ_IDLE;
		end else if (host_read) begin
			HOST_DATA_LINES_OUT <= next_read_data;
		end
	end

	// drive the bus only during a selected read with phase two high
	always_ff @(posedge CLK) begin
		if (SRST) begin
			HOST_DATA_LINES_OE <= 1'b0;
		end else begin
			HOST_DATA_LINES_OE <= selected & HOST_BUS.read_not_write
				& HOST_BUS.phase_two_clock;
		end
	end
endmodule

// ---- hdl/irq_logic_defs.svh ----
// register offsets, field positions and reset values of the interrupt logic
`ifndef IRQ_LOGIC_DEFS_SVH
`define IRQ_LOGIC_DEFS_SVH

// register select codes
`define REG_PORT_B_OUTPUT 4'h0
`define REG_PORT_A_OUTPUT 4'h1
`define REG_TIMER_ONE_COUNTER_LOW 4'h4
`define REG_TIMER_ONE_LATCH_HIGH 4'h7
`define REG_TIMER_TWO_COUNTER_LOW 4'h8
`define REG_TIMER_TWO_COUNTER_HIGH 4'h9
`define REG_SERIAL_SHIFTER 4'ha
`define REG_PERIPHERAL_CONTROL 4'hc
`define REG_INTERRUPT_FLAGS 4'hd
`define REG_INTERRUPT_ENABLES 4'he

// flag and enable bit positions
`define BIT_PORT_A_LINE_2 0
`define BIT_PORT_A_LINE_1 1
`define BIT_SHIFT_DONE 2
`define BIT_PORT_B_LINE_2 3
`define BIT_PORT_B_LINE_1 4
`define BIT_TIMER_TWO 5
`define BIT_TIMER_ONE 6
`define BIT_SUMMARY 7
`define NUM_SOURCES 7

// peripheral control fields, port a in the low nibble, port b in the high one
`define PCR_LINE_1_RISING 0
`define PCR_LINE_2_INDEPENDENT 1
`define PCR_LINE_2_RISING 2
`define PCR_LINE_2_OUTPUT 3
`define PCR_PORT_B_BASE 4

// reset values
`define FLAGS_RESET 7'h00
`define ENABLES_RESET 7'h00
`define PCR_RESET 8'h00
`define READ_IDLE 8'h00

`endif

// ---- hdl/irq_logic_pkg.sv ----
// types shared by the interrupt logic and its bench
package irq_logic_pkg;

	typedef struct packed {
		logic chip_select_high_active;
		logic chip_select_low_active_n;
		logic read_not_write;
		logic [3:0] register_select_lines;
		logic [7:0] host_data_lines;
		logic phase_two_clock;
	} host_bus_type;

	typedef struct packed {
		logic port_a_ctrl_line_1;
		logic port_a_ctrl_line_2;
		logic port_b_ctrl_line_1;
		logic port_b_ctrl_line_2;
		logic shift_done;
		logic timer_two_timeout;
		logic timer_one_timeout;
	} event_inputs_type;

endpackage

// ---- hdl/ctrl_edge_detect.sv ----
// active edge detector for one peripheral control line
module ctrl_edge_detect (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// line and chosen polarity
	input wire logic line,
	input wire logic rising_sel,
	// one-cycle pulse on the chosen edge
	output logic edge_seen
);
	logic prev;
	logic armed;

	// no edge is reported until one sample of the line has been taken
	always_ff @(posedge clk) begin
		if (srst) begin
			prev <= 1'b0;
			armed <= 1'b0;
		end else begin
			prev <= line;
			armed <= 1'b1;
		end
	end

	always_comb begin
		edge_seen = armed & (rising_sel ? (line & ~prev) : (~line & prev));
	end
endmodule

// ---- hdl/flag_cell.sv ----
// one sticky interrupt flag where a set beats a clear in the same cycle
module flag_cell (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// set and clear requests
	input wire logic set,
	input wire logic clear,
	// flag state
	output logic flag
);
	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end
endmodule

// ---- sim/irq_logic_props.sv ----
// port checks of the interrupt logic
module irq_logic_props (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// inputs
	input wire irq_logic_pkg::host_bus_type HOST_BUS,
	input wire irq_logic_pkg::event_inputs_type EVENTS,
	// outputs
	input wire logic [7:0] HOST_DATA_LINES_OUT,
	input wire logic HOST_DATA_LINES_OE,
	input wire logic INTERRUPT_REQUEST_N
);
	import irq_logic_pkg::*;
	logic p2_prev;
	logic sel;
	logic start;
	logic rd_at;
	assign sel = HOST_BUS.chip_select_high_active && !HOST_BUS.chip_select_low_active_n;
	assign start = sel && HOST_BUS.phase_two_clock && !p2_prev;
	assign rd_at = start && HOST_BUS.read_not_write;
	always_ff @(posedge CLK) begin
		p2_prev <= SRST ? 1'b0 : HOST_BUS.phase_two_clock;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	AST_RST: assert property (disable iff (1'b0) $fell(SRST) |-> INTERRUPT_REQUEST_N &&
		!HOST_DATA_LINES_OE && HOST_DATA_LINES_OUT == 8'h00) else $error("outputs not idle");
	AST_OE_ON: assert property (sel && HOST_BUS.read_not_write &&
		HOST_BUS.phase_two_clock |=> HOST_DATA_LINES_OE) else $error("read not driven");
	AST_OE_OFF: assert property (!sel |=> !HOST_DATA_LINES_OE)
		else $error("bus driven unselected");
	AST_SUM: assert property (rd_at && HOST_BUS.register_select_lines == 4'hd
		|=> HOST_DATA_LINES_OUT[7] == !INTERRUPT_REQUEST_N) else $error("summary bit wrong");
	AST_ENRD: assert property (rd_at && HOST_BUS.register_select_lines == 4'he
		|=> HOST_DATA_LINES_OUT[7]) else $error("enable bit 7 not one");
	AST_HOLD: assert property (!rd_at |=> $stable(HOST_DATA_LINES_OUT))
		else $error("read data changed");
	AST_RISE: assert property ($rose(INTERRUPT_REQUEST_N) |-> $past(start, 2) || $past(SRST))
		else $error("request released alone");
	AST_SHIFT: assert property (EVENTS.shift_done ##2 (rd_at &&
		HOST_BUS.register_select_lines == 4'hd) |=> HOST_DATA_LINES_OUT[2]) else $error("shift flag");
	AST_TMR1: assert property (EVENTS.timer_one_timeout ##2 (rd_at &&
		HOST_BUS.register_select_lines == 4'hd) |=> HOST_DATA_LINES_OUT[6]) else $error("timer flag");
endmodule

// ---- sim/host_cpu_model.sv ----
// host processor model on the register bus
module host_cpu_model (
	// clock
	input wire logic clk,
	// device read side
	input wire logic [7:0] dev_data,
	input wire logic dev_oe,
	// bus to device
	output irq_logic_pkg::host_bus_type bus
);
	timeunit 1ns;
	timeprecision 1ps;
	import irq_logic_pkg::*;
	host_bus_type req = '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0};
	logic drv = 1'b0;
	logic [7:0] wdat = 8'h00;
	logic [7:0] held = 8'h00;
	logic [7:0] lvl;
	// data wire: device, host, else holder level
	assign lvl = dev_oe ? dev_data : (drv ? wdat : held);
	always @(posedge clk) begin
		held <= lvl;
	end
	always_comb begin
		bus = req;
		bus.host_data_lines = lvl;
	end
	task automatic acc(input logic rnw, input logic [3:0] rs, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b0, rnw, rs, 8'h00, 1'b0};
		drv <= !rnw;
		wdat <= wd;
		@(posedge clk);
		req.phase_two_clock <= 1'b1;
		@(posedge clk);
		rd = 8'hxx;
		n = 0;
		while (rnw && n < 4) begin
			@(posedge clk);
			n++;
			if (dev_oe === 1'b1) begin
				rd = dev_data;
				n = 4;
			end
		end
		req <= '{1'b0, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0};
		drv <= 1'b0;
	endtask
endmodule

// ---- sim/peripheral_interrupt_logic_tb_top.sv ----
// bench top of the interrupt logic
module peripheral_interrupt_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_logic_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	host_bus_type bus;
	event_inputs_type ev = 7'b1111000;
	logic [7:0] dout;
	logic oe;
	logic irq_n;
	logic [7:0] rd;
	logic [7:0] top = 8'hff;
	int n_mismatch = 0;
	int cmp_count = 0;
	int pos[7] = '{5, 6, 2, 3, 4, 1, 0};
	logic [3:0] crs[2][7] = '{'{4'h1, 4'h1, 4'ha, 4'h0, 4'h0, 4'h9, 4'h4},
		'{4'h1, 4'h1, 4'ha, 4'h0, 4'h0, 4'h8, 4'h7}};
	logic [6:0] crw[2] = '{7'b1010101, 7'b0101010};
	initial begin
		forever #10 clk = ~clk;
	end
	peripheral_interrupt_logic DUT (.CLK(clk), .SRST(srst), .HOST_BUS(bus), .EVENTS(ev),
		.HOST_DATA_LINES_OUT(dout), .HOST_DATA_LINES_OE(oe), .INTERRUPT_REQUEST_N(irq_n));
	host_cpu_model host (.clk(clk), .dev_data(dout), .dev_oe(oe), .bus(bus));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [3:0] rs, input logic [7:0] exp);
		host.acc(1'b1, rs, 8'h00, rd);
		chk("register", exp, rd);
	endtask
	task automatic wr(input logic [3:0] rs, input logic [7:0] d);
		host.acc(1'b0, rs, d, rd);
	endtask
	task automatic raise(input int i);
		ev[pos[i]] <= ~ev[pos[i]];
		@(posedge clk);
		ev[pos[i]] <= ~ev[pos[i]];
	endtask
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd_chk(4'hd, 8'h00);
		rd_chk(4'he, 8'h80);
		rd_chk(4'h2, 8'h00);
		wr(4'he, 8'hff);
		rd_chk(4'he, 8'hff);
		wr(4'he, 8'h05);
		rd_chk(4'he, 8'hfa);
		wr(4'he, 8'hff);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 7; i++) begin
				@(posedge clk);
				fork
					raise(i);
					host.acc(1'b1, 4'hd, 8'h00, rd);
				join
				chk("flags", 8'h80 | (8'h01 << i), rd);
				chk("request", 8'h00, {7'h00, irq_n});
				if (p == 1) begin
					wr(4'he, 8'h01 << i);
					repeat (2) @(posedge clk);
					chk("request", 8'h01, {7'h00, irq_n});
					wr(4'hd, 8'h80);
					rd_chk(4'hd, 8'h01 << i);
					wr(4'he, 8'h80 | (8'h01 << i));
				end
				host.acc(crw[p][i], crs[p][i], 8'h00, rd);
				rd_chk(4'hd, 8'h00);
				chk("request", 8'h01, {7'h00, irq_n});
			end
		end
		wr(4'hc, 8'h22);
		raise(0);
		raise(3);
		rd_chk(4'h1, 8'h00);
		wr(4'h0, 8'h00);
		rd_chk(4'hd, 8'h89);
		// software scan from the highest flag down
		for (int b = 6; b >= 0; b--) begin
			if (rd[b] && top == 8'hff) begin
				top = b[7:0];
			end
		end
		chk("highest flag", 8'h03, top);
		wr(4'hd, 8'h09);
		rd_chk(4'hd, 8'h00);
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
endmodule
bind peripheral_interrupt_logic irq_logic_props props (.CLK(CLK), .SRST(SRST),
	.HOST_BUS(HOST_BUS), .EVENTS(EVENTS), .HOST_DATA_LINES_OUT(HOST_DATA_LINES_OUT),
	.HOST_DATA_LINES_OE(HOST_DATA_LINES_OE), .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N));
